// ---- hdl/dlt_tx.sv ----
// display link transmitter: parallel pixel word to four serial pairs plus clock pair
`include "dlt_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module dlt_tx (
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_PIXEL_CLOCK_IN,
    input wire logic I_POWER_DOWN_N,
    input wire logic [23:0] I_COLOUR,
    input wire logic I_LINE_SYNC,
    input wire logic I_FRAME_SYNC,
    input wire logic I_PIXEL_DATA_VALID,
    input wire logic I_SPARE_IN,
    output logic [3:0] O_DATA_P,
    output logic [3:0] O_DATA_N,
    output logic O_CLK_P,
    output logic O_CLK_N,
    output logic O_LINK_OE
);

    localparam logic [7:0] LOSS_CYC = 8'(`DLT_CLK_LOSS_CYC);
    localparam logic [6:0] CLK_PAT = `DLT_CLK_PATTERN;

    dlt_pkg::dlt_regs_t st_reg;
    dlt_pkg::dlt_regs_t st_next;
    logic fall;
    logic [8:0] sum;
    logic [27:0] par_word;

    // word layout: spare, data-valid, frame sync, line sync, colour
    assign par_word = {I_SPARE_IN, I_PIXEL_DATA_VALID, I_FRAME_SYNC, I_LINE_SYNC, I_COLOUR};
    // falling edge seen after the second sync stage
    assign fall = st_reg.pclk_d & ~st_reg.pclk_s2;
    assign sum = {1'b0, st_reg.acc} + `DLT_SLOT_STEP;

    always_comb begin
        st_next = st_reg;
        st_next.pclk_s1 = I_PIXEL_CLOCK_IN;
        st_next.pclk_s2 = st_reg.pclk_s1;
        st_next.pclk_d = st_reg.pclk_s2;
        st_next.pd_s1 = I_POWER_DOWN_N;
        st_next.pd_s2 = st_reg.pd_s1;
        st_next.dat_s1 = par_word;
        st_next.dat_s2 = st_reg.dat_s1;
        if (!st_reg.pd_s2) begin
            // power-down: stop serialising, drop lock
            st_next.state = dlt_pkg::DLT_IDLE;
            st_next.cnt = 8'h00;
            st_next.acc = 8'h00;
            st_next.slot = 3'h0;
        end else if (fall) begin
            // capture on falling edge only, measure period for tracking
            st_next.word = st_reg.dat_s2;
            st_next.period = (st_reg.cnt == `DLT_CNT_MAX) ? `DLT_CNT_MAX : st_reg.cnt + 8'h01;
            st_next.cnt = 8'h00;
            st_next.acc = 8'h00;
            st_next.slot = 3'h0;
            case (st_reg.state)
                dlt_pkg::DLT_IDLE: begin
                    st_next.state = dlt_pkg::DLT_TRACK;
                end
                dlt_pkg::DLT_TRACK, dlt_pkg::DLT_SEND: begin
                    st_next.state = dlt_pkg::DLT_SEND;
                end
                default: begin
                    st_next.state = dlt_pkg::DLT_IDLE;
                end
            endcase
        end else begin
            st_next.cnt = (st_reg.cnt == `DLT_CNT_MAX) ? `DLT_CNT_MAX : st_reg.cnt + 8'h01;
            if (st_reg.cnt >= LOSS_CYC - 8'h01) begin
                // input clock missing: back to idle, pairs low
                st_next.state = dlt_pkg::DLT_IDLE;
            end else if (st_reg.state == dlt_pkg::DLT_SEND) begin
                // seven slots spread evenly over the measured period
                if (sum >= {1'b0, st_reg.period}) begin
                    st_next.acc = 8'(sum - {1'b0, st_reg.period});
                    if (st_reg.slot != `DLT_LAST_SLOT) begin
                        st_next.slot = st_reg.slot + 3'h1;
                    end
                end else begin
                    st_next.acc = sum[7:0];
                end
            end
        end
        // drivers follow the synced pin one edge later
        st_next.oe = st_reg.pd_s2;
        st_next.clk_p = 1'b0;
        st_next.data_p = 4'h0;
        if (st_next.state == dlt_pkg::DLT_SEND) begin
            st_next.clk_p = CLK_PAT[3'h6 - st_next.slot];
            for (int k = 0; k < `DLT_PAIRS; k++) begin
                // pair k carries word bits 7k+6 down to 7k, msb first
                st_next.data_p[k] = st_next.word[k * `DLT_SLOTS + 6 - int'(st_next.slot)];
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign O_DATA_P = st_reg.data_p;
    assign O_DATA_N = ~st_reg.data_p;
    assign O_CLK_P = st_reg.clk_p;
    assign O_CLK_N = ~st_reg.clk_p;
    assign O_LINK_OE = st_reg.oe;

    chk_pd_hiz: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        !st_reg.pd_s2 |=> !O_LINK_OE && st_reg.state == dlt_pkg::DLT_IDLE)
        else $error("drivers still enabled in power-down");

    chk_idle_low: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        st_reg.state != dlt_pkg::DLT_SEND |-> O_DATA_P == 4'h0 && !O_CLK_P && O_DATA_N == 4'hF)
        else $error("pairs not low while not sending");

    chk_clock_loss: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (st_reg.pd_s2 && !fall && st_reg.cnt == LOSS_CYC - 8'h01) |=> st_reg.state == dlt_pkg::DLT_IDLE)
        else $error("missing input clock not detected");

    chk_fall_capture: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (fall && st_reg.pd_s2) |=> st_reg.word == $past(st_reg.dat_s2) && st_reg.slot == 3'h0)
        else $error("word not captured on falling edge");

    chk_rise_ignored: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (!fall && st_reg.pd_s2) |=> $stable(st_reg.word))
        else $error("word changed without falling edge");

    chk_period_track: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (fall && st_reg.pd_s2 && st_reg.cnt < 8'h20) |=> st_reg.period == $past(st_reg.cnt) + 8'h01)
        else $error("period not re-measured");

    chk_slot_range: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        st_reg.slot <= `DLT_LAST_SLOT)
        else $error("slot index beyond seven slots");

    chk_clk_pattern: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        st_reg.state == dlt_pkg::DLT_SEND |-> O_CLK_P == CLK_PAT[3'h6 - st_reg.slot])
        else $error("clock pair pattern wrong");

    chk_data_map: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        st_reg.state == dlt_pkg::DLT_SEND |-> O_DATA_P[3] == st_reg.word[27 - int'(st_reg.slot)]
            && O_DATA_P[0] == st_reg.word[6 - int'(st_reg.slot)])
        else $error("pair bit mapping wrong");

    chk_send_start: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (fall && st_reg.pd_s2 && st_reg.state != dlt_pkg::DLT_IDLE) |=> st_reg.state == dlt_pkg::DLT_SEND)
        else $error("captured word not sent");

    chk_oe_on: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        st_reg.pd_s2 |=> O_LINK_OE)
        else $error("drivers not enabled after power-down release");

    chk_pd_quiet: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        !st_reg.pd_s2 |=> O_DATA_P == 4'h0 && !O_CLK_P)
        else $error("serialiser still running in power-down");

    chk_word_hold_pd: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        !st_reg.pd_s2 |=> $stable(st_reg.word))
        else $error("word captured in power-down");

    chk_track_first: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (fall && st_reg.pd_s2 && st_reg.state == dlt_pkg::DLT_IDLE)
            |=> st_reg.state == dlt_pkg::DLT_TRACK && O_DATA_P == 4'h0)
        else $error("first edge after idle did not only measure");

    chk_idle_wait: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (!fall && st_reg.state == dlt_pkg::DLT_IDLE) |=> st_reg.state == dlt_pkg::DLT_IDLE)
        else $error("left idle without falling edge");

    chk_clk_first: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (fall && st_reg.pd_s2 && st_reg.state != dlt_pkg::DLT_IDLE) |=> O_CLK_P && !O_CLK_N)
        else $error("clock pair not high in first slot");

    chk_capture_slot0: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (fall && st_reg.pd_s2 && st_reg.state != dlt_pkg::DLT_IDLE)
            |=> O_DATA_P[0] == $past(st_reg.dat_s2[6]) && O_DATA_P[3] == $past(st_reg.dat_s2[27]))
        else $error("captured word not in first slot");

    chk_slot_step: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (st_reg.pd_s2 && !fall && st_reg.state == dlt_pkg::DLT_SEND)
            |=> st_reg.slot == $past(st_reg.slot) || st_reg.slot == $past(st_reg.slot) + 3'h1)
        else $error("slot skipped or went back");

    chk_slot_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (st_reg.pd_s2 && !fall && st_reg.slot == `DLT_LAST_SLOT)
            |=> st_reg.slot == `DLT_LAST_SLOT)
        else $error("last slot not held until next edge");

    chk_slots_fit: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (st_reg.state == dlt_pkg::DLT_SEND && st_reg.period >= 8'h07
            && st_reg.cnt == st_reg.period - 8'h01) |-> st_reg.slot == `DLT_LAST_SLOT)
        else $error("seven slots do not fit in one period");

    chk_acc_range: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (st_reg.state == dlt_pkg::DLT_SEND && st_reg.period >= 8'h08) |-> st_reg.acc < st_reg.period)
        else $error("slot accumulator out of range");

    chk_loss_quiet: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (st_reg.pd_s2 && !fall && st_reg.cnt >= LOSS_CYC - 8'h01) |=> O_DATA_P == 4'h0 && !O_CLK_P)
        else $error("pairs not low after clock loss");

    chk_no_false_loss: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (st_reg.pd_s2 && !fall && st_reg.state == dlt_pkg::DLT_SEND && st_reg.cnt < LOSS_CYC - 8'h01)
            |=> st_reg.state == dlt_pkg::DLT_SEND)
        else $error("sending stopped while clock present");

    chk_cnt_restart: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (fall && st_reg.pd_s2) |=> st_reg.cnt == 8'h00)
        else $error("period count not restarted on edge");

    // every pair against its own slice of the word
    for (genvar k = 0; k < `DLT_PAIRS; k++) begin : g_pair_chk
        chk_pair_map: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
            st_reg.state == dlt_pkg::DLT_SEND |-> O_DATA_P[k] == st_reg.word[k * `DLT_SLOTS + 6 - int'(st_reg.slot)])
            else $error("pair slot bit wrong");
    end

endmodule : dlt_tx

`default_nettype wire

// ---- hdl/dlt_defines.svh ----
// timing and layout constants of the display link transmitter
`ifndef DLT_DEFINES_SVH
`define DLT_DEFINES_SVH

`define DLT_SYS_PERIOD_NS 4
`define DLT_PCLK_MAX_PERIOD_NS 56
`define DLT_CLK_LOSS_NS 120
`define DLT_CLK_LOSS_CYC ((`DLT_CLK_LOSS_NS) / (`DLT_SYS_PERIOD_NS))
`define DLT_PD_MIN_PULSE_US 1
`define DLT_PAIRS 4
`define DLT_SLOTS 7
`define DLT_WORD_W 28
`define DLT_COLOUR_W 24
`define DLT_LAST_SLOT 3'h6
`define DLT_SLOT_STEP 9'h007
`define DLT_CLK_PATTERN 7'h63
`define DLT_CNT_MAX 8'hFF

`endif

// ---- hdl/dlt_pkg.sv ----
// types of the display link transmitter
package dlt_pkg;

    typedef enum logic [1:0] {
        DLT_IDLE  = 2'h0,
        DLT_TRACK = 2'h1,
        DLT_SEND  = 2'h3
    } dlt_state_t;

    typedef struct packed {
        logic pclk_s1;
        logic pclk_s2;
        logic pclk_d;
        logic pd_s1;
        logic pd_s2;
        logic [27:0] dat_s1;
        logic [27:0] dat_s2;
        logic [27:0] word;
        logic [7:0] cnt;
        logic [7:0] period;
        logic [7:0] acc;
        logic [2:0] slot;
        dlt_state_t state;
        logic [3:0] data_p;
        logic clk_p;
        logic oe;
    } dlt_regs_t;

endpackage : dlt_pkg

// ---- dv/dlt_src_model.sv ----
// pixel source model: pixel clock and parallel word
`timescale 1ns/1ns
`default_nettype none

module dlt_src_model (
    input wire logic i_run,
    input wire logic [27:0] i_word,
    output logic o_pclk,
    output logic [27:0] o_word
);
    initial begin
        o_pclk = 1'b0;
        o_word = 28'h0000000;
        #1;
        forever begin
            if (i_run) begin
                o_pclk = 1'b1;
                o_word = i_word;
                #24;
                o_pclk = 1'b0;
                #24;
            end else begin
                // clock stands low, data lines scramble
                o_word = ~o_word;
                #4;
            end
        end
    end
endmodule : dlt_src_model
`default_nettype wire

// ---- dv/dlt_tx_tb_top.sv ----
// testbench of the display link transmitter
`timescale 1ns/1ns
`default_nettype none

module dlt_tx_tb_top;
    logic i_clock, i_rst_n, i_pd_n, run, pclk;
    logic [27:0] word, src;
    logic [3:0] o_data_p, o_data_n;
    logic o_clk_p, o_clk_n, o_oe;
    int bad_count = 0;
    int n_checks = 0;

    dlt_src_model SRC (.i_run(run), .i_word(word), .o_pclk(pclk), .o_word(src));
    dlt_tx DUT (.I_CLOCK(i_clock), .I_RST_N(i_rst_n), .I_PIXEL_CLOCK_IN(pclk), .I_POWER_DOWN_N(i_pd_n),
        .I_COLOUR(src[23:0]), .I_LINE_SYNC(src[24]), .I_FRAME_SYNC(src[25]),
        .I_PIXEL_DATA_VALID(src[26]), .I_SPARE_IN(src[27]), .O_DATA_P(o_data_p), .O_DATA_N(o_data_n),
        .O_CLK_P(o_clk_p), .O_CLK_N(o_clk_n), .O_LINK_OE(o_oe));

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end

    function automatic logic [3:0] slot_of(input logic [27:0] w, input int s);
        return {w[27-s], w[20-s], w[13-s], w[6-s]};
    endfunction : slot_of

    task automatic cmp(input logic [4:0] got, input logic [4:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic t_word(input logic [27:0] w);
        @(negedge i_clock);
        word = w;
        run = 1'b1;
        repeat (3) @(negedge pclk);
        repeat (4) @(posedge i_clock);
        @(negedge i_clock);
        cmp({o_oe, o_data_p}, {1'b1, slot_of(w, 0)}, "first slot");
        cmp({o_clk_p, o_data_n}, {1'b1, ~slot_of(w, 0)}, "clock high, pair inverse");
        repeat (5) @(posedge i_clock);
        @(negedge i_clock);
        cmp({o_clk_n, 4'h0}, 5'h10, "clock low mid word");
        cmp({o_clk_p, o_data_p}, {1'b0, slot_of(w, 3)}, "fourth slot");
        @(negedge pclk);
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        cmp({o_clk_p, o_data_p}, {1'b1, slot_of(w, 6)}, "last slot");
        $display("test word %h done", w);
    endtask : t_word

    task automatic t_clk_loss;
        @(negedge i_clock);
        run = 1'b0;
        repeat (40) @(negedge i_clock);
        cmp({o_oe, o_data_p}, 5'h10, "pairs low on clock loss");
        cmp({o_clk_p, o_data_n}, 5'h0F, "clock pair low");
        $display("test clock loss done");
    endtask : t_clk_loss

    task automatic t_power_down;
        @(negedge i_clock);
        i_pd_n = 1'b0;
        repeat (250) @(negedge i_clock);
        cmp({o_oe, o_data_p}, 5'h00, "drivers off in power-down");
        i_pd_n = 1'b1;
        repeat (4) @(negedge i_clock);
        cmp({o_oe, 4'h0}, 5'h10, "drivers on after power-down");
        $display("test power-down done");
    endtask : t_power_down

    task automatic t_reset;
        @(negedge i_clock);
        i_rst_n = 1'b0;
        @(negedge i_clock);
        cmp({o_oe, o_data_p}, 5'h00, "outputs idle in reset");
        cmp({o_clk_n, o_data_n}, 5'h1F, "inverse sides in reset");
        repeat (7) @(negedge i_clock);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_clock);
        cmp({o_oe, o_data_p}, 5'h00, "drivers wait for synced power-down");
        @(negedge i_clock);
        cmp({o_oe, o_data_p}, 5'h10, "drivers on after reset");
        $display("test mid-run reset done");
    endtask : t_reset

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    initial begin
        i_rst_n = 1'b0;
        i_pd_n = 1'b1;
        run = 1'b1;
        word = 28'h1234567;
        repeat (8) @(negedge i_clock);
        i_rst_n = 1'b1;
        t_word(28'hAB56AD5);
        t_word(28'h5A3C1E7);
        t_clk_loss();
        t_word(28'h0F0F0F1);
        t_power_down();
        t_reset();
        t_word(28'hFEDCBA9);
        finish_test();
    end

    initial begin
        #50000;
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule : dlt_tx_tb_top
`default_nettype wire
